// [rtl/rtc_alarm_interrupt_unit.sv]
// Alarm compare, alarm flag, interrupt pin and two-wire register slave.

// ==========================================================
module rtc_alarm_interrupt_unit
	import rtc_alarm_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = rtc_alarm_pkg::DEFAULT_SLAVE
) (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst,
	// Timekeeping counters and shared interrupt request
	input  wire rtc_alarm_pkg::time_now_s time_now,
	input  wire logic                    minute_rollover,
	input  wire logic                    other_irq_req,
	// Two-wire bus pins
	input  wire logic                    scl_i,
	output logic                         scl_o,
	output logic                         scl_oe,
	input  wire logic                    sda_i,
	output logic                         sda_o,
	output logic                         sda_oe,
	// Interrupt pin, open drain, active low
	output logic                         irq_n_o,
	output logic                         irq_n_oe
);
	import rtc_alarm_pkg::*;

	// ==========================================================
	// Elaboration checks
	// Reserved address groups would collide with other bus traffic.
	if (SLAVE_ADDR[6:3] == 4'h0 || SLAVE_ADDR[6:3] == 4'hF) begin : g_chk
		$error("Slave address lies in a reserved range.");
	end

	// The pointer is four bits wide, so the map must hold sixteen bytes.
	if (REG_COUNT != 2 ** $bits(ADDR_CONTROL)) begin : g_map_chk
		$error("Register map size does not match the pointer width.");
	end

	// ==========================================================
	// Pin synchronisers
	// A third stage keeps the previous level for edge and condition finding.
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic       scl_q;
	logic       sda_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], scl_i};
			sda_sync <= {sda_sync[0], sda_i};
			scl_q    <= scl_sync[1];
			sda_q    <= sda_sync[1];
		end
	end

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	assign scl_s     = scl_sync[1];
	assign sda_s     = sda_sync[1];
	assign scl_rise  = scl_s & ~scl_q;
	assign scl_fall  = ~scl_s & scl_q;
	assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
	assign bus_stop  = scl_s & scl_q & ~sda_q & sda_s;

	// ==========================================================
	// Register file
	logic [7:0] reg_file [REG_COUNT];
	logic       alarm_flag;
	logic [3:0] reg_ptr;
	logic [7:0] shifter;
	logic       wr_strobe;
	logic       alarm_hit;

	// Time bytes read the live counters; writes there land in spare RAM.
	logic [7:0] read_value;
	always_comb begin
		unique case (reg_ptr)
			ADDR_MINUTE:  read_value = {1'b0, time_now.minute};
			ADDR_HOUR:    read_value = {2'h0, time_now.hour};
			ADDR_WEEKDAY: read_value = {1'b0, time_now.weekday};
			ADDR_DATE:    read_value = {2'h0, time_now.date};
			ADDR_FLAG: begin
				read_value = reg_file[ADDR_FLAG] & FLAG_RW_MASK;
				read_value[BIT_ALARM_FLAG] = alarm_flag;
			end
			ADDR_CONTROL: read_value = reg_file[ADDR_CONTROL] & CTRL_RW_MASK;
			default:      read_value = reg_file[reg_ptr];
		endcase
	end

	// Alarm and plain RAM bytes keep every bit the host writes.
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				reg_file[i] <= REG_RESET_VAL;
			end
		end else if (wr_strobe) begin
			reg_file[reg_ptr] <= shifter;
		end
	end

	logic       week_or_date_target_select;
	logic       alarm_irq_enable;
	logic       clock_reset;
	logic [7:0] min_alm;
	logic [7:0] hour_alm;
	logic [7:0] wd_alm;

	assign week_or_date_target_select =
		reg_file[ADDR_EXTENSION][BIT_WEEK_OR_DATE];
	assign alarm_irq_enable = reg_file[ADDR_CONTROL][BIT_ALARM_IRQ_EN];
	assign clock_reset      = reg_file[ADDR_CONTROL][BIT_CLOCK_RESET];
	assign min_alm          = reg_file[ADDR_MINUTE_ALM];
	assign hour_alm         = reg_file[ADDR_HOUR_ALM];
	assign wd_alm           = reg_file[ADDR_WD_ALM];

	// ==========================================================
	// Alarm compare
	logic min_ok;
	logic hour_ok;
	logic day_ok;
	logic day_field_eq;

	// The hour alarm bit 6 is spare storage and never compared.
	// Weekday mode ANDs the masks, so any one shared day is enough.
	always_comb begin
		if (week_or_date_target_select) begin
			day_field_eq = wd_alm[5:0] == time_now.date;
		end else begin
			day_field_eq = |(wd_alm[6:0] & time_now.weekday);
		end
	end

	assign min_ok  = min_alm[BIT_COMPARE_DISABLE] |
		(min_alm[6:0] == time_now.minute);
	assign hour_ok = hour_alm[BIT_COMPARE_DISABLE] |
		(hour_alm[5:0] == time_now.hour);
	assign day_ok  = wd_alm[BIT_COMPARE_DISABLE] | day_field_eq;

	// Comparing only on the rollover means an alarm equal to the time
	// already shown waits for the counters to come round again.
	assign alarm_hit = minute_rollover & ~clock_reset &
		min_ok & hour_ok & day_ok;

	logic flag_write;
	assign flag_write = wr_strobe && reg_ptr == ADDR_FLAG;

	// A new event in the clearing cycle wins over the clear.
	always_ff @(posedge clk) begin
		if (rst) begin
			alarm_flag <= 1'b0;
		end else if (alarm_hit) begin
			alarm_flag <= 1'b1;
		end else if (flag_write && !shifter[BIT_ALARM_FLAG]) begin
			alarm_flag <= 1'b0;
		end
	end

	// ==========================================================
	// Interrupt pin
	logic alarm_irq_req;

	// Enable gates the flag level, so an enable set late still asserts.
	assign alarm_irq_req = alarm_flag & alarm_irq_enable;

	// The pin is open drain: only its enable moves, its level stays low.
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_n_oe <= 1'b0;
			irq_n_o  <= 1'b0;
		end else begin
			irq_n_o  <= 1'b0;
			// No timer releases the pin; only the flag, the enable or other_irq_req do.
			irq_n_oe <= alarm_irq_req | other_irq_req;
		end
	end

	// ==========================================================
	// Bus slave
	bus_state_e state;
	logic [3:0] bit_cnt;
	logic       read_mode;
	logic       ptr_loaded;
	logic       master_nack;

	logic       byte_done;

	// A byte is complete at the clock fall that follows its eighth bit.
	assign byte_done = scl_fall && bit_cnt == BITS_PER_BYTE;
	assign wr_strobe = state == ST_WRITE && byte_done;

	// This slave never stretches the clock, so its clock pin stays off.
	always_ff @(posedge clk) begin
		if (rst) begin
			scl_o  <= 1'b0;
			scl_oe <= 1'b0;
			sda_o  <= 1'b0;
		end else begin
			scl_o  <= 1'b0;
			scl_oe <= 1'b0;
			sda_o  <= 1'b0;
		end
	end

	// Start and stop outrank the bit engine, so a cut frame ends cleanly.
	// There is no bus timeout; a stalled master leaves the slave waiting.
	always_ff @(posedge clk) begin
		if (rst) begin
			state       <= ST_IDLE;
			bit_cnt     <= 4'h0;
			shifter     <= 8'h00;
			read_mode   <= 1'b0;
			ptr_loaded  <= 1'b0;
			master_nack <= 1'b0;
			reg_ptr     <= 4'h0;
			sda_oe      <= 1'b0;
		end else if (bus_start) begin
			state      <= ST_ADDR;
			bit_cnt    <= 4'h0;
			ptr_loaded <= 1'b0;
			sda_oe     <= 1'b0;
		end else if (bus_stop) begin
			state  <= ST_IDLE;
			sda_oe <= 1'b0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					sda_oe <= 1'b0;
				end
				ST_ADDR, ST_PTR, ST_WRITE: begin
					if (scl_rise) begin
						shifter <= {shifter[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (byte_done) begin
						bit_cnt <= 4'h0;
						if (state == ST_ADDR) begin
							if (shifter[7:1] == SLAVE_ADDR) begin
								read_mode <= shifter[0];
								state     <= ST_ACK_OUT;
								sda_oe    <= 1'b1;
							end else begin
								state <= ST_IDLE;
							end
						end else begin
							if (state == ST_PTR) begin
								reg_ptr    <= shifter[3:0];
								ptr_loaded <= 1'b1;
							end else begin
								reg_ptr <= reg_ptr + 4'h1;
							end
							state  <= ST_ACK_OUT;
							sda_oe <= 1'b1;
						end
					end
				end
				ST_ACK_OUT: begin
					if (scl_fall) begin
						if (read_mode) begin
							state   <= ST_READ;
							shifter <= read_value;
							sda_oe  <= ~read_value[7];
						end else begin
							state  <= ptr_loaded ? ST_WRITE : ST_PTR;
							sda_oe <= 1'b0;
						end
					end
				end
				ST_READ: begin
					// Each fall moves the next bit out while the clock is low.
					if (scl_fall) begin
						if (bit_cnt == LAST_BIT) begin
							bit_cnt <= 4'h0;
							state   <= ST_ACK_IN;
							sda_oe  <= 1'b0;
							reg_ptr <= reg_ptr + 4'h1;
						end else begin
							bit_cnt <= bit_cnt + 4'h1;
							shifter <= {shifter[6:0], 1'b0};
							sda_oe  <= ~shifter[6];
						end
					end
				end
				ST_ACK_IN: begin
					// The answer is taken at the rise and acted on at the fall.
					if (scl_rise) begin
						master_nack <= sda_s;
					end else if (scl_fall) begin
						if (master_nack) begin
							state <= ST_IDLE;
						end else begin
							state   <= ST_READ;
							shifter <= read_value;
							sda_oe  <= ~read_value[7];
						end
					end
				end
				default: begin
					state  <= ST_IDLE;
					sda_oe <= 1'b0;
				end
			endcase
		end
	end

endmodule : rtc_alarm_interrupt_unit

// [rtl/rtc_alarm_pkg.sv]
// Shared constants, types and register map for the alarm and bus block.
package rtc_alarm_pkg;

	// ==========================================================
	// Register map
	localparam logic [3:0] ADDR_MINUTE      = 4'h1;
	localparam logic [3:0] ADDR_HOUR        = 4'h2;
	localparam logic [3:0] ADDR_WEEKDAY     = 4'h3;
	localparam logic [3:0] ADDR_DATE        = 4'h4;
	localparam logic [3:0] ADDR_MINUTE_ALM  = 4'h8;
	localparam logic [3:0] ADDR_HOUR_ALM    = 4'h9;
	localparam logic [3:0] ADDR_WD_ALM      = 4'hA;
	localparam logic [3:0] ADDR_EXTENSION   = 4'hD;
	localparam logic [3:0] ADDR_FLAG        = 4'hE;
	localparam logic [3:0] ADDR_CONTROL     = 4'hF;
	localparam int         REG_COUNT        = 16;

	// ==========================================================
	// Field positions
	localparam int BIT_COMPARE_DISABLE = 7;
	localparam int BIT_WEEK_OR_DATE    = 6;
	localparam int BIT_ALARM_FLAG      = 3;
	localparam int BIT_ALARM_IRQ_EN    = 3;
	localparam int BIT_CLOCK_RESET     = 0;

	localparam logic [7:0] FLAG_RW_MASK  = 8'h37;
	localparam logic [7:0] CTRL_RW_MASK  = 8'hFD;
	localparam logic [7:0] REG_RESET_VAL = 8'h00;

	// ==========================================================
	// Bus framing
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_BIT      = 4'h7;
	localparam logic [6:0] DEFAULT_SLAVE = 7'h32;

	// Current time from the timekeeping counters, BCD, 24-hour.
	typedef struct packed {
		logic [6:0] minute;
		logic [5:0] hour;
		logic [6:0] weekday;
		logic [5:0] date;
	} time_now_s;

	typedef enum logic [6:0] {
		ST_IDLE    = 7'b0000001,
		ST_ADDR    = 7'b0000010,
		ST_PTR     = 7'b0000100,
		ST_WRITE   = 7'b0001000,
		ST_READ    = 7'b0010000,
		ST_ACK_OUT = 7'b0100000,
		ST_ACK_IN  = 7'b1000000
	} bus_state_e;

endpackage : rtc_alarm_pkg

// [dv/rtc_alarm_chk.sv]
// Pin-level checks for the alarm unit.
module rtc_alarm_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Watched pins
	input wire logic other_irq_req,
	input wire logic minute_rollover,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic irq_n_o,
	input wire logic irq_n_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Assertions
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	AST_SCL_OE: assert property (!scl_oe)
		else $error("clock line pulled");
	AST_SCL_O: assert property (!scl_o)
		else $error("clock driven high");
	AST_SDA_O: assert property (!sda_o)
		else $error("data driven high");
	AST_IRQ_O: assert property (!irq_n_o)
		else $error("irq driven high");
	AST_OTHER: assert property (other_irq_req |=> irq_n_oe)
		else $error("shared irq not low");
	AST_SDA_CHG: assert property ($changed(sda_oe) |-> !scl_i)
		else $error("data moved with clock high");
	// Only a bus write or a dropped shared source may release the pin.
	AST_IRQ_FALL: assert property ($fell(irq_n_oe) |->
		!$past(other_irq_req) && (!scl_i || $past(other_irq_req, 2)))
		else $error("irq released by itself");
	AST_IRQ_RISE: assert property ($rose(irq_n_oe) |->
		$past(other_irq_req) || $past(minute_rollover, 2) || !scl_i)
		else $error("irq without cause");
endmodule : rtc_alarm_chk

bind rtc_alarm_interrupt_unit rtc_alarm_chk chk_u (.clk(clk), .rst(rst),
	.other_irq_req(other_irq_req), .minute_rollover(minute_rollover),
	.scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
	.sda_oe(sda_oe), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));

// [dv/i2c_host_model.sv]
// Two-wire bus master standing in for the host processor.
module i2c_host_model (
	// Wire level
	input  wire logic sda,
	// Open-drain pulls, high pulls the line low
	output logic       scl_dn,
	output logic       sda_dn,
	// Read byte report
	output logic       rd_v,
	output logic [7:0] rd_q
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Bus phases
	initial begin
		scl_dn = 1'b0;
		sda_dn = 1'b0;
		rd_v = 1'b0;
		rd_q = 8'h00;
	end
	// The clock stands still between frames.
	task automatic bit_io(input logic b, output logic r);
		sda_dn = !b;
		#40 scl_dn = 1'b0;
		#40 r = sda;
		#40 scl_dn = 1'b1;
		#40;
	endtask : bit_io
	task automatic start();
		sda_dn = 1'b0;
		#40 scl_dn = 1'b0;
		#40 sda_dn = 1'b1;
		#40 scl_dn = 1'b1;
		#40;
	endtask : start
	task automatic stop();
		sda_dn = 1'b1;
		#40 scl_dn = 1'b0;
		#40 sda_dn = 1'b0;
		#40;
	endtask : stop
	task automatic byte_io(input logic [7:0] d, input logic b9,
		input logic rd, output logic r9);
		logic [7:0] q;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(b9, r9);
		if (rd) begin
			rd_q = q;
			rd_v = 1'b1;
			rd_v <= #1 1'b0;
		end
	endtask : byte_io
endmodule : i2c_host_model

// [dv/tb_top.sv]
// Self-checking bench for the alarm unit.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import rtc_alarm_pkg::*;
	logic clk, rst, roll, other, scl_dn, sda_dn, rd_v, ack;
	logic scl_o, scl_oe, sda_o, sda_oe, irq_o, irq_oe;
	logic [7:0] rd_q;
	logic [15:0] lfsr = 16'h7D6F;
	time_now_s tnow;
	logic [7:0] exp_q[$];
	int mismatches, samples_checked;
	wire scl = !(scl_dn | scl_oe);
	wire sda = !(sda_dn | sda_oe);
	// Rows: control, extension, minute, hour, day, hit.
	logic [7:0] tab [10][6] = '{
		'{8'h08, 8'h00, 8'h30, 8'h07, 8'h2A, 8'h01},
		'{8'h08, 8'h00, 8'h30, 8'h07, 8'h01, 8'h00},
		'{8'h08, 8'h40, 8'h30, 8'h07, 8'h15, 8'h01},
		'{8'h08, 8'h40, 8'h30, 8'h07, 8'h14, 8'h00},
		'{8'h08, 8'h00, 8'h80, 8'h07, 8'h08, 8'h01},
		'{8'h08, 8'h00, 8'h80, 8'h80, 8'h80, 8'h01},
		'{8'h00, 8'h00, 8'h30, 8'h07, 8'h08, 8'h01},
		'{8'h08, 8'h00, 8'h31, 8'h07, 8'h08, 8'h00},
		'{8'h08, 8'h00, 8'h30, 8'h17, 8'h08, 8'h00},
		'{8'h09, 8'h00, 8'h30, 8'h07, 8'h08, 8'h00}};
	rtc_alarm_interrupt_unit dut_u (.clk(clk), .rst(rst), .time_now(tnow),
		.minute_rollover(roll), .other_irq_req(other), .scl_i(scl),
		.scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe), .irq_n_o(irq_o), .irq_n_oe(irq_oe));
	i2c_host_model host_u (.sda(sda), .scl_dn(scl_dn), .sda_dn(sda_dn),
		.rd_v(rd_v), .rd_q(rd_q));
	// ==========
	// Tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done();
		$display("mismatches %0d checks %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next
	task automatic snd(input logic [7:0] d);
		logic a;
		host_u.byte_io(d, 1'b1, 1'b0, a);
		chk({7'h00, a}, 8'h00);
	endtask : snd
	task automatic wr(input logic [7:0] b[$]);
		host_u.start();
		snd({DEFAULT_SLAVE, 1'b0});
		foreach (b[i]) snd(b[i]);
		host_u.stop();
	endtask : wr
	task automatic rd(input logic [3:0] p, input int n);
		logic a;
		host_u.start();
		snd({DEFAULT_SLAVE, 1'b0});
		snd({4'h0, p});
		host_u.start();
		snd({DEFAULT_SLAVE, 1'b1});
		for (int i = 1; i <= n; i++) host_u.byte_io(8'hFF, i == n, 1'b1, a);
		host_u.stop();
	endtask : rd
	always @(posedge rd_v) begin
		chk(rd_q, exp_q.pop_front());
	end
	// ==========
	// Sequence
	initial begin
		clk = 1'b0;
		forever #2.5 clk = !clk;
	end
	initial begin
		#450us;
		mismatches++;
		test_done();
	end
	initial begin
		rst = 1'b1;
		roll = 1'b0;
		other = 1'b0;
		tnow = '{7'h30, 6'h07, 7'h08, 6'h15};
		repeat (16) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		repeat (8) @(negedge clk);
		wr('{8'h0F, 8'h08, 8'h5A});
		exp_q = '{8'h08, 8'h5A, 8'h30};
		rd(4'hF, 3);
		host_u.start();
		host_u.byte_io({DEFAULT_SLAVE ^ 7'h01, 1'b0}, 1'b1, 1'b0, ack);
		host_u.stop();
		chk({7'h00, ack}, 8'h01);
		foreach (tab[r]) begin
			wr('{8'h08, tab[r][2], tab[r][3], tab[r][4], 8'h00, 8'h00,
				tab[r][1], 8'h00, tab[r][0]});
			chk({7'h00, irq_oe}, 8'h00);
			@(negedge clk) roll = 1'b1;
			@(negedge clk) roll = 1'b0;
			repeat (3) @(negedge clk);
			chk({7'h00, irq_oe}, tab[r][5] & tab[r][0] >> 3);
			wr('{8'h0E, 8'h08});
			exp_q.push_back({4'h0, tab[r][5][0], 3'h0});
			rd(4'hE, 1);
			chk({7'h00, irq_oe}, tab[r][5] & tab[r][0] >> 3);
			wr('{8'h0E, 8'h00});
			repeat (8) @(negedge clk);
			chk({7'h00, irq_oe}, 8'h00);
		end
		// Enable alone releases and restores the pin while the flag holds.
		wr('{8'h08, 8'h30, 8'h07, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h08});
		exp_q = '{8'h30, 8'h07, 8'h08};
		rd(4'h8, 3);
		@(negedge clk) roll = 1'b1;
		@(negedge clk) roll = 1'b0;
		repeat (3) @(negedge clk);
		chk({7'h00, irq_oe}, 8'h01);
		wr('{8'h0F, 8'h00});
		repeat (8) @(negedge clk);
		chk({7'h00, irq_oe}, 8'h00);
		wr('{8'h0F, 8'h08});
		repeat (8) @(negedge clk);
		chk({7'h00, irq_oe}, 8'h01);
		wr('{8'h0E, 8'h00});
		repeat (8) @(negedge clk);
		chk({7'h00, irq_oe}, 8'h00);
		repeat (40) begin
			@(negedge clk) other = lfsr[0];
			lfsr = lfsr_next(lfsr);
			@(negedge clk);
			chk({7'h00, irq_oe}, {7'h00, other});
		end
		test_done();
	end
endmodule : tb_top
